/* File: fsp_pkg.sv */
// Package for the flash status poller: command codes, states, timing counts and carriers.
// Assumes a 100 MHz core clock and an asynchronous NOR flash bus with 16-bit data.
package fsp_pkg;

  // ************************************************************
  // Status word bit positions
  // ************************************************************
  localparam int POLL_BIT_POS = 7;        // poll_complement_bit
  localparam int TOGGLE_ONE_POS = 6;      // toggle_bit_one
  localparam int TIMEOUT_POS = 5;         // timeout_flag
  localparam int ERASE_WIN_POS = 3;       // erase_window_flag
  localparam int SECTOR_TOGGLE_POS = 2;   // sector_toggle_bit

  // ************************************************************
  // Bus widths and timing
  // ************************************************************
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_ACCESS_NS = 100;    // Strobe low time per read cycle
  localparam int STROBE_HIGH_NS = 30;     // Strobe high gap between cycles
  localparam int RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  localparam logic [7:0] RESET_ADDR = 8'h00;

  // Poll method chosen by the user
  typedef enum logic [1:0] {
    FSP_M_POLL = 2'b00,
    FSP_M_TOGGLE = 2'b01,
    FSP_M_WINDOW = 2'b10
  } fsp_mode_t;

  // Final verdict
  typedef enum logic [1:0] {
    FSP_R_NONE = 2'b00,
    FSP_R_DONE = 2'b01,
    FSP_R_FAIL = 2'b10,
    FSP_R_WIN_SHUT = 2'b11
  } fsp_result_t;

  // Sequencer states
  typedef enum logic [3:0] {
    FSP_IDLE = 4'b0000,
    FSP_RD_LOW = 4'b0001,
    FSP_RD_GAP = 4'b0010,
    FSP_EVAL = 4'b0011,
    FSP_WR_LOW = 4'b0100,
    FSP_WR_GAP = 4'b0101,
    FSP_FINISH = 4'b0110
  } fsp_state_t;

  // User request carrier
  typedef struct packed {
    fsp_mode_t mode;
    logic [ADDR_W-1:0] addr;
    logic [7:0] expect_data;
  } fsp_req_t;

  // Flash pin carrier (outputs of the poller)
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } fsp_pins_t;

endpackage : fsp_pkg

/* File: fsp_poller.sv */
// Host-side status poller for a parallel NOR flash running an embedded algorithm.
// Assumes the flash bus pins are driven straight from this module; dq input is asynchronous.
`timescale 1ns/1ps

// How it works
// R1: Poll only after final write strobe.
// R2: Buffered program: poll last loaded address.
// R3: Programming shows inverted bit 7 until done.
// R4: Suspended program allows array reads only.
// R5: Protected program: busy briefly, then array.
// R6: Erase polling reads 0, then 1.
// R7: Erase poll address inside erasing sector.
// R8: Protected erase: busy briefly, no erase.
// R9: After poll flip, use later read data.
// R10: Timeout seen: reread polling bit once.
// R11: First toggle bit flips per read.
// R12: Protected erase toggles briefly then standby.
// R13: Suspend stops first toggle bit.
// R14: Erase-suspend programming toggles until done.
// R15: Erase window bit 0, then 1.
// R16: Window closed: only erase suspend accepted.
// R17: Check window bit around added erases.
// R18: Sector toggle bit flips in erasing sectors.
// R19: Two reads; unchanged toggle means done.
// R20: Toggling with timeout: recheck, then reset.
// R21: Restarting toggle check begins with double read.
// R22: Status same at every address.
// R23: Timeout flag marks failed operation.
// R24: Toggles change once per read cycle.
module fsp_poller (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire fsp_pkg::fsp_req_t req_in,
  input wire logic abandon_in,
  input wire logic [fsp_pkg::DATA_W-1:0] dq_in,
  output fsp_pkg::fsp_pins_t pins_out,
  output logic busy_out,
  output logic done_out,
  output fsp_pkg::fsp_result_t result_out,
  output logic [7:0] last_status_out,
  output logic window_open_out
);
  import fsp_pkg::*;

  // ************************************************************
  // Data input synchroniser
  // ************************************************************
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
  logic [DATA_W-1:0] nxt_dq_s1, nxt_dq_s2, nxt_dq_s3;
  logic dq_stable;

  // Three stages; value trusted when the last two agree
  always_comb begin
    nxt_dq_s1 = dq_in;
    nxt_dq_s2 = dq_s1_ff;
    nxt_dq_s3 = dq_s2_ff;
  end
  assign dq_stable = (dq_s2_ff == dq_s3_ff);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      dq_s3_ff <= '0;
    end else if (clk_en_in) begin
      dq_s1_ff <= nxt_dq_s1;
      dq_s2_ff <= nxt_dq_s2;
      dq_s3_ff <= nxt_dq_s3;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  fsp_state_t state_ff, nxt_state;
  fsp_req_t req_ff, nxt_req;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [1:0] nreads_ff, nxt_nreads;   // Reads since the check began
  logic prev_tog_ff, nxt_prev_tog;
  logic to_seen_ff, nxt_to_seen;
  logic flip_seen_ff, nxt_flip_seen;
  fsp_pins_t pins_ff, nxt_pins;
  logic busy_ff, nxt_busy, done_ff, nxt_done, win_ff, nxt_win;
  fsp_result_t res_ff, nxt_res;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] smp;
  logic poll_true, toggled;

  assign smp = dq_s3_ff[7:0];
  assign poll_true = (smp[POLL_BIT_POS] == req_ff.expect_data[POLL_BIT_POS]);
  assign toggled = (smp[TOGGLE_ONE_POS] != prev_tog_ff);

  // Next-state logic for the read, evaluate and reset sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_cnt = cnt_ff;
    nxt_nreads = nreads_ff;
    nxt_prev_tog = prev_tog_ff;
    nxt_to_seen = to_seen_ff;
    nxt_flip_seen = flip_seen_ff;
    nxt_pins = pins_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_win = win_ff;
    nxt_res = res_ff;
    nxt_stat = stat_ff;
    case (state_ff)
      FSP_IDLE: begin
        // Caller starts only after its final write strobe, see R1
        if (start_in) begin
          nxt_req = req_in;   // Last loaded / erasing-sector address, see R2 see R7
          nxt_nreads = 2'h0;  // Fresh start clears the read count, so toggle mode re-reads twice, see R21
          nxt_to_seen = 1'b0;
          nxt_flip_seen = 1'b0;
          nxt_busy = 1'b1;
          nxt_res = FSP_R_NONE;
          nxt_state = FSP_RD_LOW;
          nxt_cnt = 4'(RD_CYC);
          nxt_pins.ce_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
          nxt_pins.addr = req_in.addr;
        end
      end
      FSP_RD_LOW: begin
        // One strobe pulse per read so toggles step once, see R24
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (dq_stable) begin
          nxt_stat = smp;
          nxt_pins.ce_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_state = FSP_EVAL;
        end
      end
      FSP_EVAL: begin
        nxt_state = FSP_RD_GAP;
        nxt_cnt = 4'(GAP_CYC);
        if (nreads_ff != 2'h3) begin
          nxt_nreads = nreads_ff + 2'h1;
        end
        nxt_prev_tog = smp[TOGGLE_ONE_POS];
        case (req_ff.mode)
          FSP_M_POLL: begin
            // True bit 7 ends; the data is taken from a later read, see R3 see R6 see R9
            if (poll_true && flip_seen_ff) begin
              nxt_res = FSP_R_DONE;
              nxt_state = FSP_FINISH;
            end else if (poll_true) begin
              nxt_flip_seen = 1'b1;
            end else if (to_seen_ff) begin
              nxt_res = FSP_R_FAIL;     // Second look still inverted, see R10 see R23
              nxt_state = FSP_WR_LOW;
            end else if (smp[TIMEOUT_POS]) begin
              nxt_to_seen = 1'b1;
            end
          end
          FSP_M_TOGGLE: begin
            // Compare two consecutive reads, see R19 see R11
            if (nreads_ff != 2'h0 && !toggled) begin
              nxt_res = FSP_R_DONE;
              nxt_state = FSP_FINISH;
            end else if (nreads_ff != 2'h0 && to_seen_ff) begin
              nxt_res = FSP_R_FAIL;     // Still toggling after recheck, see R20
              nxt_state = FSP_WR_LOW;
            end else if (nreads_ff != 2'h0 && smp[TIMEOUT_POS]) begin
              nxt_to_seen = 1'b1;
            end
          end
          default: begin
            // Window check ahead of an added sector erase, see R15 see R17
            nxt_win = ~smp[ERASE_WIN_POS];
            nxt_res = smp[ERASE_WIN_POS] ? FSP_R_WIN_SHUT : FSP_R_DONE;
            nxt_state = FSP_FINISH;
          end
        endcase
        if (abandon_in) begin
          nxt_state = FSP_FINISH;       // Returning needs a new start, see R21
          nxt_res = FSP_R_NONE;
        end
      end
      FSP_RD_GAP: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = FSP_RD_LOW;
          nxt_cnt = 4'(RD_CYC);
          nxt_pins.ce_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
        end
      end
      FSP_WR_LOW: begin
        // Reset command restores array reads
        if (cnt_ff == 4'(RD_CYC)) begin
          nxt_pins.ce_n = 1'b0;
          nxt_pins.we_n = 1'b0;
          nxt_pins.dq_oe = 1'b1;
          nxt_pins.dq = RESET_CMD;
          nxt_pins.addr = ADDR_W'(RESET_ADDR);
          nxt_cnt = cnt_ff - 4'h1;
        end else if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_pins.we_n = 1'b1;
          nxt_state = FSP_WR_GAP;
          nxt_cnt = 4'(GAP_CYC);
        end
      end
      FSP_WR_GAP: begin
        nxt_pins.ce_n = 1'b1;
        nxt_pins.dq_oe = 1'b0;
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_state = FSP_FINISH;
        end
      end
      FSP_FINISH: begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_state = FSP_IDLE;
      end
      default: begin
        nxt_state = FSP_IDLE;
      end
    endcase
    if (state_ff == FSP_EVAL && nxt_state == FSP_WR_LOW) begin
      nxt_cnt = 4'(RD_CYC);
    end
  end

  // Registers of the sequencer
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= FSP_IDLE;
      req_ff <= '0;
      cnt_ff <= 4'h0;
      nreads_ff <= 2'h0;
      prev_tog_ff <= 1'b0;
      to_seen_ff <= 1'b0;
      flip_seen_ff <= 1'b0;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, addr: '0, dq: '0};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      win_ff <= 1'b0;
      res_ff <= FSP_R_NONE;
      stat_ff <= 8'h00;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      cnt_ff <= nxt_cnt;
      nreads_ff <= nxt_nreads;
      prev_tog_ff <= nxt_prev_tog;
      to_seen_ff <= nxt_to_seen;
      flip_seen_ff <= nxt_flip_seen;
      pins_ff <= nxt_pins;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      win_ff <= nxt_win;
      res_ff <= nxt_res;
      stat_ff <= nxt_stat;
    end
  end

  assign pins_out = pins_ff;
  assign busy_out = busy_ff;
  assign done_out = done_ff;
  assign result_out = res_ff;
  assign last_status_out = stat_ff;
  assign window_open_out = win_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_fail_eval;
    state_ff == FSP_EVAL && nxt_res == FSP_R_FAIL && !abandon_in && clk_en_in;
  endsequence

  a_fail_sends_reset: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R20
    s_fail_eval |=> (state_ff == FSP_WR_LOW)) else $error("Failure did not start reset write");
  a_toggle_two_reads: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R19
    (state_ff == FSP_EVAL && req_ff.mode == FSP_M_TOGGLE && nreads_ff == 2'h0 && clk_en_in)
    |=> res_ff == FSP_R_NONE) else $error("Toggle verdict after a single read");
  a_strobe_single: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R24
    (state_ff == FSP_EVAL) |-> pins_ff.oe_n) else $error("Output enable low during evaluate");
  a_poll_retry_to: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R10
    (state_ff == FSP_EVAL && req_ff.mode == FSP_M_POLL && !to_seen_ff && clk_en_in)
    |=> res_ff != FSP_R_FAIL) else $error("Fail declared without polling bit recheck");
  a_poll_later_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R9
    (state_ff == FSP_EVAL && req_ff.mode == FSP_M_POLL && !flip_seen_ff && clk_en_in)
    |=> res_ff != FSP_R_DONE) else $error("Done declared on the flip read itself");
  a_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R19
    done_out && clk_en_in |=> !done_out && !busy_out) else $error("Done not a single pulse");
  a_no_write_while_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R1
    !pins_ff.oe_n |-> pins_ff.we_n && !pins_ff.dq_oe) else $error("Write overlaps read");
  a_window_result: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // see R15
    (res_ff == FSP_R_WIN_SHUT && done_out) |-> !window_open_out) else $error("Window flag wrong");

endmodule : fsp_poller

/* File: fsp_flash_model.sv */
// Behavioural flash device answering reads with a status word while busy and not suspended, array data otherwise.
// Assumes the bench loads each operation by a pulse on load_in before polling starts.
`timescale 1ns/1ps
module fsp_flash_model (
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [15:0] dq_in,
  input wire logic load_in,
  input wire logic [7:0] reads_in,
  input wire logic [7:0] data_in,
  input wire logic erase_in,
  input wire logic tmo_in,
  input wire logic win_in,
  input wire logic hold_in,
  output logic [15:0] dq_out,
  output int resets_out
);
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic [7:0] left = 8'h00;
  logic [15:0] last = 16'h0000;
  logic [7:0] stat;
  logic [15:0] word;
  // Status word, the same at every address
  assign stat = {erase_in ? 1'b0 : ~data_in[7], tog, tmo_in, 1'b0, win_in,
                 erase_in & tog, 2'b00};
  // Suspended operation gives array data only
  assign word = (busy && !hold_in) ? {8'h00, stat} : {8'h00, data_in};
  // Released bus shows the inverse of the last word
  assign dq_out = (!ce_n_in && !oe_n_in) ? word : ~last;
  // Each completed read cycle while busy advances the algorithm and flips toggles
  always @(posedge oe_n_in) begin
    last = word;
    // Suspend freezes the toggle and the algorithm
    if (busy && !hold_in) begin
      tog = ~tog;
      if (left != 8'h00) left = left - 8'h01;
      if (left == 8'h00 && !tmo_in) busy = 1'b0;
    end
  end
  // Reset command ends a failed algorithm
  always @(posedge we_n_in) begin
    if (!ce_n_in && dq_in == 16'h00F0) begin
      busy = 1'b0;
      resets_out = resets_out + 1;
    end
  end
  // Busy for a set number of reads, then array data; with tmo_in set it stays busy until a reset command
  always @(posedge load_in) begin
    left = reads_in;
    busy = 1'b1;
  end
  initial resets_out = 0;
endmodule : fsp_flash_model

/* File: fsp_poller_bench.sv */
// Self-checking bench for the flash status poller driving a behavioural device.
// Assumes the device model is compiled first; stimulus changes at falling edges.
`timescale 1ns/1ps
module fsp_poller_bench;
  import fsp_pkg::*;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic start_in = 1'b0;
  fsp_req_t req_in = '0;
  logic [15:0] dq;
  fsp_pins_t pins;
  logic busy, done, win_open;
  fsp_result_t result;
  logic [7:0] status;
  logic load = 1'b0;
  logic [7:0] reads = 8'h00;
  logic [7:0] data = 8'h00;
  logic erase = 1'b0, tmo = 1'b0, win = 1'b0;
  logic clk_en = 1'b1, abandon = 1'b0, hold = 1'b0;
  int resets;
  int fail_count = 0;
  int n_checks = 0;

  // ********************
  // Clock, design and device
  // ********************
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  fsp_poller i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
    .start_in(start_in), .req_in(req_in), .abandon_in(abandon), .dq_in(dq),
    .pins_out(pins), .busy_out(busy), .done_out(done), .result_out(result),
    .last_status_out(status), .window_open_out(win_open));
  fsp_flash_model i_flash (.ce_n_in(pins.ce_n), .oe_n_in(pins.oe_n), .we_n_in(pins.we_n),
    .dq_in(pins.dq), .load_in(load), .reads_in(reads), .data_in(data), .erase_in(erase),
    .tmo_in(tmo), .win_in(win), .hold_in(hold), .dq_out(dq), .resets_out(resets));

  // ********************
  // Shared tasks
  // ********************
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
      fail_count++;
    end
  endtask : check

  // Loads the device and raises start for one cycle
  task automatic launch(input fsp_mode_t m, input logic [25:0] a, input logic [7:0] d,
                        input logic [7:0] n, input logic [2:0] flags);
    @(negedge core_clk_in);
    {erase, tmo, win} = flags;
    data = d;
    reads = n;
    load = 1'b1;
    req_in = '{mode: m, addr: a, expect_data: d};
    start_in = 1'b1;
    @(negedge core_clk_in);
    load = 1'b0;
    start_in = 1'b0;
  endtask : launch

  // Waits for done, checking the poll address on every read
  task automatic wait_done(input logic [25:0] a);
    int i;
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      if (pins.oe_n === 1'b0) check(pins.addr, a);
      @(negedge core_clk_in);
    end
    if (i == 3000) begin
      fail_count++;
      summarize();
    end
  endtask : wait_done

  // Loads the device, starts one check and waits for its end
  task automatic run(input fsp_mode_t m, input logic [25:0] a, input logic [7:0] d,
                     input logic [7:0] n, input logic [2:0] flags);
    launch(m, a, d, n, flags);
    wait_done(a);
  endtask : run

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    check({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, busy, done}, 6'b111000);
    check({result, status, win_open}, 11'h000);
  endtask : t_reset

  task automatic t_program();
    run(FSP_M_POLL, 26'h0001234, 8'hA5, 8'h03, 3'b000);
    check(result, FSP_R_DONE);
    check(status, 8'hA5);
    run(FSP_M_POLL, 26'h2000002, 8'h3C, 8'h01, 3'b000);
    check(result, FSP_R_DONE);
    check(status, 8'h3C);
  endtask : t_program

  task automatic t_erase();
    run(FSP_M_POLL, 26'h3FF0000, 8'hFF, 8'h04, 3'b100);
    check(result, FSP_R_DONE);
    check(status, 8'hFF);
  endtask : t_erase

  task automatic t_toggle();
    run(FSP_M_TOGGLE, 26'h0000010, 8'h5A, 8'h05, 3'b000);
    check(result, FSP_R_DONE);
    check(status, 8'h5A);
    run(FSP_M_TOGGLE, 26'h1000000, 8'hFF, 8'h01, 3'b100);
    check(result, FSP_R_DONE);
    check(status, 8'hFF);
  endtask : t_toggle

  task automatic t_fail();
    int r0;
    r0 = resets;
    run(FSP_M_TOGGLE, 26'h0000100, 8'h11, 8'h02, 3'b010);
    check(result, FSP_R_FAIL);
    check(resets, r0 + 1);
    run(FSP_M_POLL, 26'h0000200, 8'h80, 8'h02, 3'b010);
    check(result, FSP_R_FAIL);
    check(resets, r0 + 2);
    check({pins.ce_n, pins.we_n, pins.dq_oe, busy}, 4'b1100);
  endtask : t_fail

  task automatic t_window();
    run(FSP_M_WINDOW, 26'h0400000, 8'hFF, 8'h08, 3'b100);
    check(win_open, 1'b1);
    run(FSP_M_WINDOW, 26'h0400000, 8'hFF, 8'h08, 3'b101);
    check(result, FSP_R_WIN_SHUT);
    check(win_open, 1'b0);
  endtask : t_window

  // Leaving the check early, then restarting it from scratch
  task automatic t_abandon();
    abandon = 1'b1;
    run(FSP_M_TOGGLE, 26'h0000040, 8'h5A, 8'h05, 3'b000);
    check(result, FSP_R_NONE);
    abandon = 1'b0;
    run(FSP_M_TOGGLE, 26'h0000040, 8'h5A, 8'h05, 3'b000);
    check(result, FSP_R_DONE);
    check(status, 8'h5A);
  endtask : t_abandon

  // Suspended device: no toggling, array data on every read
  task automatic t_suspend();
    hold = 1'b1;
    run(FSP_M_TOGGLE, 26'h0000080, 8'h33, 8'h20, 3'b000);
    check(result, FSP_R_DONE);
    check(status, 8'h33);
    hold = 1'b0;
  endtask : t_suspend

  // Clock enable low holds the strobes and state mid-read
  task automatic t_freeze();
    logic [10:0] snap;
    launch(FSP_M_POLL, 26'h0000300, 8'h96, 8'h02, 3'b000);
    repeat (5) @(negedge core_clk_in);
    clk_en = 1'b0;
    snap = {pins.ce_n, pins.oe_n, busy, status};
    repeat (20) @(negedge core_clk_in);
    check({pins.ce_n, pins.oe_n, busy, status}, snap);
    clk_en = 1'b1;
    wait_done(26'h0000300);
    check(result, FSP_R_DONE);
    check(status, 8'h96);
  endtask : t_freeze

  initial begin
    repeat (10) @(negedge core_clk_in);
    rstn_in = 1'b1;
    t_reset();
    t_program();
    t_erase();
    t_toggle();
    t_fail();
    t_window();
    t_abandon();
    t_suspend();
    t_freeze();
    summarize();
  end
endmodule : fsp_poller_bench
